// ---- design/dbl_bank_legality.sv ----
// What this block does
// - Actions use current and previous CKE sample
// - Nop and deselect start nothing new
// - Idle bank: activate, auto refresh, mode set
// - Active bank: read or write burst start
// - Precharge closes the open row
// - Precharge truncates a read burst
// - Precharge truncates a write burst
// - Burst terminate hits the latest read burst
// - Legality only with CKE high twice, after exit
// - Idle only after precharge time passes
// - Row active after row-to-column delay, no burst
// - Other banks work freely during bursts
// - CKE low with a nop enters power-down; high exits
// - A10 picks one bank or all banks
`timescale 1ns/1ns
`include "dbl_consts.svh"

module dbl_bank_legality #(
  parameter int NUM_BANKS = 4,
  parameter int BURST_LEN = `DBL_BURST_LEN
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   cke_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   ras_n_i,
  input  wire logic                   cas_n_i,
  input  wire logic                   we_n_i,
  input  wire logic [1:0]             bank_addr_i,
  input  wire logic                   a10_i,
  output dbl_pkg::dbl_bank_st_t       bank_state_o [NUM_BANKS],
  output dbl_pkg::dbl_glob_st_t       glob_state_o,
  output logic                        all_idle_o,
  output logic                        read_ready_o,
  output logic                        cmd_illegal_o,
  output logic [1:0]                  last_read_bank_o
);
  import dbl_pkg::*;

  localparam logic [7:0] TRP_C   = 8'(`DBL_TRP_CYC);
  localparam logic [7:0] TRCD_C  = 8'(`DBL_TRCD_CYC);
  localparam logic [7:0] TRFC_C  = 8'(`DBL_TRFC_CYC);
  localparam logic [7:0] TXSNR_C = 8'(`DBL_TXSNR_CYC);
  localparam logic [7:0] TMRD_C  = 8'(`DBL_TMRD_CK);
  localparam logic [7:0] DLL_C   = 8'(`DBL_DLL_LOCK_CK);
  localparam logic [7:0] BURST_C = 8'(BURST_LEN / 2);
  localparam logic [7:0] BAP_C   = 8'(BURST_LEN / 2 + `DBL_TRP_CYC);

  // --------------------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------------------
  logic         cke_prev_reg;
  dbl_glob_st_t glob_reg;
  dbl_glob_st_t glob_next;
  logic [7:0]   glob_tmr_reg;
  logic [7:0]   glob_tmr_next;
  logic [7:0]   dll_cnt_reg;
  logic [7:0]   dll_cnt_next;
  logic [1:0]   last_rd_reg;
  dbl_bank_st_t bank_st [NUM_BANKS];
  dbl_bank_st_t bank_nx [NUM_BANKS];
  logic [NUM_BANKS-1:0] pre_ok;
  logic [NUM_BANKS-1:0] idle_now;
  logic [NUM_BANKS-1:0] idle_nx;

  wire cmd_nop  = cs_n_i | (ras_n_i & cas_n_i & we_n_i);
  wire cmd_act  = ~cs_n_i & ~ras_n_i &  cas_n_i &  we_n_i;
  wire cmd_ref  = ~cs_n_i & ~ras_n_i & ~cas_n_i &  we_n_i;
  wire cmd_mrs  = ~cs_n_i & ~ras_n_i & ~cas_n_i & ~we_n_i;
  wire cmd_rd   = ~cs_n_i &  ras_n_i & ~cas_n_i &  we_n_i;
  wire cmd_wr   = ~cs_n_i &  ras_n_i & ~cas_n_i & ~we_n_i;
  wire cmd_pre  = ~cs_n_i & ~ras_n_i &  cas_n_i & ~we_n_i;
  wire cmd_bst  = ~cs_n_i &  ras_n_i &  cas_n_i & ~we_n_i;

  // both CKE samples high; and global state normal
  wire exec     = cke_prev_reg & cke_i & (glob_reg == GL_NORMAL) & ~cmd_nop;
  wire all_idle = &idle_now;

  dbl_bank_st_t tgt_st;
  assign tgt_st = bank_st[bank_addr_i];

  wire tgt_idle  = (tgt_st == BK_IDLE);
  wire tgt_open  = (tgt_st == BK_ACTIVE) | (tgt_st == BK_READ) | (tgt_st == BK_WRITE);
  wire dll_ready = (dll_cnt_reg == 8'h00);

  wire ok_act = cmd_act & tgt_idle;
  // read held off until the lock count ends
  wire ok_rd  = cmd_rd & tgt_open & dll_ready;
  wire ok_wr  = cmd_wr & ((tgt_st == BK_ACTIVE) | (tgt_st == BK_WRITE));
  // all banks must be prechargeable for precharge-all
  wire ok_pre = cmd_pre & (a10_i ? (&pre_ok) : (tgt_open | tgt_idle));
  // terminate only a live read burst
  wire ok_bst = cmd_bst & (bank_st[last_rd_reg] == BK_READ);
  // refresh and mode set need every bank idle
  wire ok_ref = cmd_ref & all_idle;
  wire ok_mrs = cmd_mrs & all_idle;

  wire go_act = exec & ok_act;
  wire go_rd  = exec & ok_rd;
  wire go_wr  = exec & ok_wr;
  wire go_pre = exec & ok_pre;
  wire go_bst = exec & ok_bst;
  wire go_ref = exec & ok_ref;
  wire go_mrs = exec & ok_mrs;

  // anything not listed is flagged and ignored
  wire legal_any = ok_act | ok_rd | ok_wr | ok_pre | ok_bst | ok_ref | ok_mrs;
  // only nop while a global interval runs
  wire glob_busy = (glob_reg == GL_SR_EXIT) | (glob_reg == GL_REFRESHING) | (glob_reg == GL_MODE_REG);
  wire illegal   = (exec & ~legal_any) | (glob_busy & ~cmd_nop);

  // --------------------------------------------------------------------------
  // Per-bank state and timers
  // --------------------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < NUM_BANKS; b++) begin : g_bank
      dbl_bank_st_t st_reg;
      dbl_bank_st_t st_next;
      logic [7:0]   tmr_reg;
      logic [7:0]   tmr_next;
      // each bank decodes only its own address
      // A10 widens a precharge to every bank
      wire sel     = (bank_addr_i == 2'(b));
      wire pre_hit = go_pre & (a10_i | sel);
      wire tdone   = (tmr_reg == 8'h01);

      // each bank owns its state and timer
      always_comb begin
        st_next  = st_reg;
        tmr_next = (tmr_reg == 8'h00) ? 8'h00 : tmr_reg - 8'h01;
        case (st_reg)
          BK_IDLE: begin
            if (go_act & sel) begin
              st_next  = BK_ACTIVATING;
              tmr_next = TRCD_C;
            end
          end
          // row opens once the row-to-column delay ends
          BK_ACTIVATING: begin
            if (tdone) st_next = BK_ACTIVE;
          end
          // no command taken until the timer ends
          BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING: begin
            if (tdone) st_next = BK_IDLE;
          end
          default: begin
            // finished burst returns to row active
            if ((st_reg != BK_ACTIVE) & tdone) st_next = BK_ACTIVE;
            if (go_bst & (last_rd_reg == 2'(b))) st_next = BK_ACTIVE;
            if ((go_rd | go_wr) & sel) begin
              // read or write burst, optionally auto precharge
              st_next  = go_rd ? (a10_i ? BK_READ_AP : BK_READ) : (a10_i ? BK_WRITE_AP : BK_WRITE);
              tmr_next = a10_i ? BAP_C : BURST_C;
            end
            if (pre_hit) begin
              st_next  = BK_PRECHARGING;
              tmr_next = TRP_C;
            end
          end
        endcase
      end

      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          st_reg  <= BK_IDLE;
          tmr_reg <= 8'h00;
        end else begin
          st_reg  <= st_next;
          tmr_reg <= tmr_next;
        end
      end

      assign bank_st[b]  = st_reg;
      assign bank_nx[b]  = st_next;
      assign idle_now[b] = (st_reg == BK_IDLE);
      assign idle_nx[b]  = (st_next == BK_IDLE);
      assign pre_ok[b]   = (st_reg == BK_IDLE) | (st_reg == BK_ACTIVE) | (st_reg == BK_READ) | (st_reg == BK_WRITE);
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Global power, refresh and mode register state
  // --------------------------------------------------------------------------
  wire glob_tdone = (glob_tmr_reg == 8'h01);
  wire cke_fall   = cke_prev_reg & ~cke_i;
  wire cke_rise   = ~cke_prev_reg & cke_i;

  always_comb begin
    glob_next     = glob_reg;
    glob_tmr_next = (glob_tmr_reg == 8'h00) ? 8'h00 : glob_tmr_reg - 8'h01;
    dll_cnt_next  = (dll_cnt_reg == 8'h00) ? 8'h00 : dll_cnt_reg - 8'h01;
    case (glob_reg)
      GL_NORMAL: begin
        // power-down only from nop; self refresh from refresh
        if (cke_fall & all_idle & cmd_ref) begin
          glob_next = GL_SELF_REFRESH;
        end else if (cke_fall & cmd_nop) begin
          glob_next = GL_POWER_DOWN;
        end else if (go_ref) begin
          glob_next     = GL_REFRESHING;
          glob_tmr_next = TRFC_C;
        end else if (go_mrs) begin
          // mode register delay blocks every bank
          glob_next     = GL_MODE_REG;
          glob_tmr_next = TMRD_C;
        end
      end
      // exit with CKE high and a nop
      GL_POWER_DOWN: begin
        if (cke_rise & cmd_nop) glob_next = GL_NORMAL;
      end
      GL_SELF_REFRESH: begin
        if (cke_rise & cmd_nop) begin
          glob_next     = GL_SR_EXIT;
          glob_tmr_next = TXSNR_C;
          // lock count restarts on each self refresh exit
          dll_cnt_next  = DLL_C;
        end
      end
      GL_SR_EXIT, GL_REFRESHING, GL_MODE_REG: begin
        if (glob_tdone) glob_next = GL_NORMAL;
      end
      default: begin
        glob_next = GL_NORMAL;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Registers and outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cke_prev_reg <= 1'b0;
      glob_reg     <= GL_NORMAL;
      glob_tmr_reg <= 8'h00;
      dll_cnt_reg  <= 8'h00;
      last_rd_reg  <= 2'h0;
    end else begin
      cke_prev_reg <= cke_i;
      glob_reg     <= glob_next;
      glob_tmr_reg <= glob_tmr_next;
      dll_cnt_reg  <= dll_cnt_next;
      // remember the bank of the latest read
      if (go_rd) last_rd_reg <= bank_addr_i;
    end
  end

  // Outputs other than cmd_illegal_o are registered from the next values so they line up with the
  // internal state rather than lagging it by a cycle.
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      glob_state_o     <= GL_NORMAL;
      all_idle_o       <= 1'b1;
      read_ready_o     <= 1'b1;
      cmd_illegal_o    <= 1'b0;
      last_read_bank_o <= 2'h0;
      for (int i = 0; i < NUM_BANKS; i++) bank_state_o[i] <= BK_IDLE;
    end else begin
      glob_state_o     <= glob_next;
      all_idle_o       <= &idle_nx;
      read_ready_o     <= (dll_cnt_next == 8'h00);
      cmd_illegal_o    <= illegal;
      last_read_bank_o <= go_rd ? bank_addr_i : last_rd_reg;
      for (int i = 0; i < NUM_BANKS; i++) bank_state_o[i] <= bank_nx[i];
    end
  end

endmodule

// ---- design/dbl_consts.svh ----
`ifndef DBL_CONSTS_SVH
`define DBL_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define DBL_CLK_NS       40
`define DBL_TRP_NS       15
`define DBL_TRCD_NS      15
`define DBL_TRFC_NS      70
`define DBL_TXSNR_NS     75
`define DBL_TMRD_CK      2
`define DBL_DLL_LOCK_CK  200
`define DBL_BURST_LEN    4

// Least times round up to whole cycles.
`define DBL_TRP_CYC   ((`DBL_TRP_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_TRCD_CYC  ((`DBL_TRCD_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_TRFC_CYC  ((`DBL_TRFC_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)
`define DBL_TXSNR_CYC ((`DBL_TXSNR_NS + `DBL_CLK_NS - 1) / `DBL_CLK_NS)

`endif

// ---- design/dbl_pkg.sv ----
package dbl_pkg;

  typedef enum logic [2:0] {
    BK_IDLE,
    BK_ACTIVATING,
    BK_ACTIVE,
    BK_READ,
    BK_WRITE,
    BK_READ_AP,
    BK_WRITE_AP,
    BK_PRECHARGING
  } dbl_bank_st_t;

  typedef enum logic [2:0] {
    GL_NORMAL,
    GL_POWER_DOWN,
    GL_SELF_REFRESH,
    GL_SR_EXIT,
    GL_REFRESHING,
    GL_MODE_REG
  } dbl_glob_st_t;

endpackage

// ---- verification/dbl_bank_legality_asserts.sv ----
`timescale 1ns/1ns
module dbl_bank_legality_asserts #(
  parameter int NUM_BANKS = 4,
  parameter int BURST_LEN = 4
) (
  input wire logic             core_clk_i,
  input wire logic             rst_i,
  input wire logic             cke_i,
  input wire logic             cs_n_i,
  input wire logic             ras_n_i,
  input wire logic             cas_n_i,
  input wire logic             we_n_i,
  input wire logic [1:0]       bank_addr_i,
  input wire logic             a10_i,
  input dbl_pkg::dbl_bank_st_t bank_state_o [NUM_BANKS],
  input dbl_pkg::dbl_glob_st_t glob_state_o,
  input wire logic             all_idle_o,
  input wire logic             read_ready_o,
  input wire logic             cmd_illegal_o,
  input wire logic [1:0]       last_read_bank_o
);
  import dbl_pkg::*;
  // ----
  // Command decode
  // ----
  // The clock enable sample starts low after reset, so no command is judged on the first edge.
  logic         cke_prev_reg;
  dbl_bank_st_t tgt;
  wire [3:0]    cmd  = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  wire          nop  = cs_n_i | (cmd == 4'h7);
  wire          live = cke_prev_reg & cke_i & (glob_state_o == GL_NORMAL);
  assign tgt = bank_state_o[bank_addr_i];
  always_ff @(posedge core_clk_i) begin
    cke_prev_reg <= rst_i ? 1'h0 : cke_i;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_act_opens_row: assert property (
    live && cmd == 4'h3 && tgt == BK_IDLE |=> bank_state_o[$past(bank_addr_i)] == BK_ACTIVATING ##1
    bank_state_o[$past(bank_addr_i, 2)] == BK_ACTIVE) else $error("row not opened");
  a_act_refused: assert property (
    live && cmd == 4'h3 && tgt == BK_ACTIVATING |=> cmd_illegal_o) else $error("activate not refused");
  a_rd_ap_close: assert property (
    live && cmd == 4'h5 && a10_i && read_ready_o && tgt == BK_ACTIVE ##1 cs_n_i [*3] |->
    bank_state_o[$past(bank_addr_i, 3)] == BK_READ_AP ##1 bank_state_o[$past(bank_addr_i, 4)] == BK_IDLE)
    else $error("auto precharge read length");
  a_pre_closes_row: assert property (
    live && cmd == 4'h2 && !a10_i && tgt == BK_ACTIVE |=> bank_state_o[$past(bank_addr_i)] == BK_PRECHARGING
    ##1 bank_state_o[$past(bank_addr_i, 2)] == BK_IDLE) else $error("precharge length");
  a_pre_cuts_burst: assert property (
    live && cmd == 4'h2 && !a10_i && (tgt == BK_READ || tgt == BK_WRITE) |=>
    bank_state_o[$past(bank_addr_i)] == BK_PRECHARGING) else $error("burst not cut");
  a_bst_latest_read: assert property (
    live && cmd == 4'h6 && bank_state_o[last_read_bank_o] == BK_READ |=>
    bank_state_o[$past(last_read_bank_o)] == BK_ACTIVE) else $error("terminate missed");
  a_busy_refuses: assert property (
    cke_prev_reg && cke_i && !nop && (glob_state_o == GL_REFRESHING || glob_state_o == GL_MODE_REG) |=>
    cmd_illegal_o) else $error("busy command taken");
  a_sr_exit_lock: assert property (
    glob_state_o == GL_SELF_REFRESH && !cke_prev_reg && cke_i && nop |=> glob_state_o == GL_SR_EXIT && !read_ready_o)
    else $error("self refresh exit");

  cover property (live && cmd == 4'h6);
  cover property (live && cmd == 4'h2 && a10_i);
  cover property (glob_state_o == GL_SR_EXIT);
endmodule

bind dbl_bank_legality dbl_bank_legality_asserts #(.NUM_BANKS(NUM_BANKS), .BURST_LEN(BURST_LEN)) u_asserts (.*);

// ---- verification/dbl_ctl_model.sv ----
`timescale 1ns/1ns
module dbl_ctl_model (
  input  wire logic  core_clk_i,
  output logic       cke_o,
  output logic       cs_n_o,
  output logic [2:0] cmd_o,
  output logic [1:0] bank_addr_o,
  output logic       a10_o
);
  logic [6:0] q [$];
  initial begin
    cke_o = 1'h1;
    {cs_n_o, cmd_o, bank_addr_o, a10_o} = 7'h7F;
  end
  // ----
  // Command bus
  // ----
  // Gaps get deselects.
  // Deselected lines flip so a stale command never reads as valid.
  always @(posedge core_clk_i) begin
    if (q.size() > 0) begin
      {cke_o, cmd_o, bank_addr_o, a10_o} <= q.pop_front();
      cs_n_o <= 1'h0;
    end else begin
      {cs_n_o, cmd_o, bank_addr_o, a10_o} <= {1'h1, ~cmd_o, ~bank_addr_o, ~a10_o};
    end
  end
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
module testbench;
  import dbl_pkg::*;
  localparam logic [2:0] ACT = 3'h3, REF = 3'h1, MRS = 3'h0, RD = 3'h5;
  localparam logic [2:0] WR = 3'h4, PRE = 3'h2, BST = 3'h6, NOP = 3'h7;
  logic         clk = 1'h0;
  logic         rst = 1'h1;
  int           error_cnt = 0;
  int           samples_checked = 0;
  wire          cke, cs_n, a10, idle, rdy, ill;
  wire [2:0]    cmd;
  wire [1:0]    ba, lrb;
  dbl_bank_st_t bs [4];
  dbl_glob_st_t gs;
  always #20 clk = ~clk;
  dbl_ctl_model u_ctl (.core_clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd), .bank_addr_o(ba), .a10_o(a10));
  dbl_bank_legality u_dut (.core_clk_i(clk), .rst_i(rst), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(cmd[2]),
    .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_addr_i(ba), .a10_i(a10), .bank_state_o(bs), .glob_state_o(gs),
    .all_idle_o(idle), .read_ready_o(rdy), .cmd_illegal_o(ill), .last_read_bank_o(lrb));
  // ----
  // Tests
  // ----
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic put(input logic [2:0] c, input logic [1:0] b = 2'h0, input logic a = 1'h0, input logic k = 1'h1);
    u_ctl.q.push_back({k, c, b, a});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_reset;
    tick(2);
    chk(idle === 1'h1 && gs === GL_NORMAL && rdy === 1'h1 && ill === 1'h0, "reset");
    $display("t_reset done");
  endtask
  task automatic t_rows;
    put(ACT, 2'h1); tick(2); chk(bs[1] === BK_ACTIVATING, "activating");
    tick(1); chk(bs[1] === BK_ACTIVE, "active");
    put(RD, 2'h1); put(BST); tick(2); chk(bs[1] === BK_READ && lrb === 2'h1, "read");
    tick(1); chk(bs[1] === BK_ACTIVE, "terminate");
    put(PRE, 2'h1); put(ACT, 2'h1); tick(2); chk(bs[1] === BK_PRECHARGING, "precharge");
    tick(1); chk(ill === 1'h1 && bs[1] === BK_IDLE, "precharging refuses");
    $display("t_rows done");
  endtask
  task automatic t_bursts;
    put(ACT, 2'h2); put(ACT, 2'h2); tick(3); chk(ill === 1'h1 && bs[2] === BK_ACTIVE, "double act");
    put(WR, 2'h2); put(ACT, 2'h0); tick(2); chk(bs[2] === BK_WRITE, "write");
    tick(1); chk(bs[0] === BK_ACTIVATING && bs[2] === BK_WRITE, "other bank");
    put(WR, 2'h2); put(PRE, 2'h2); tick(3); chk(bs[2] === BK_PRECHARGING, "write cut");
    put(RD, 2'h0, 1'h1); tick(2); chk(bs[0] === BK_READ_AP, "read ap");
    tick(3); chk(bs[0] === BK_IDLE, "ap idle");
    put(ACT, 2'h3); tick(3); put(WR, 2'h3); put(RD, 2'h3); tick(3);
    chk(bs[3] === BK_READ && lrb === 2'h3, "read cuts write");
    put(PRE, 2'h1, 1'h1); tick(2); chk(bs[3] === BK_PRECHARGING, "pre all");
    tick(1); chk(idle === 1'h1, "all idle");
    $display("t_bursts done");
  endtask
  task automatic t_global;
    put(BST); tick(2); chk(ill === 1'h1 && idle === 1'h1, "stray terminate");
    put(ACT, 2'h1); put(REF); tick(3); chk(ill === 1'h1 && gs === GL_NORMAL, "refresh refused");
    put(PRE, 2'h1); tick(3); put(REF); put(ACT); tick(2); chk(gs === GL_REFRESHING, "refreshing");
    tick(1); chk(ill === 1'h1, "refresh busy");
    tick(1); chk(gs === GL_NORMAL, "refresh end");
    put(MRS); tick(2); chk(gs === GL_MODE_REG, "mode set");
    tick(2); chk(gs === GL_NORMAL, "mode end");
    $display("t_global done");
  endtask
  task automatic t_power;
    put(NOP, 2'h0, 1'h0, 1'h0); tick(2); chk(gs === GL_POWER_DOWN, "power down");
    put(NOP); tick(2); chk(gs === GL_NORMAL, "wake");
    put(REF, 2'h0, 1'h0, 1'h0); tick(2); chk(gs === GL_SELF_REFRESH, "self refresh");
    put(NOP); tick(2); chk(gs === GL_SR_EXIT && rdy === 1'h0, "exit");
    put(ACT); tick(2); chk(ill === 1'h1 && bs[0] === BK_IDLE, "exit busy");
    tick(197); chk(rdy === 1'h0, "lock wait");
    tick(1); chk(rdy === 1'h1, "locked");
    $display("t_power done");
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_rows();
    t_bursts();
    t_global();
    t_power();
    finish_test();
  end
  initial begin
    #50000;
    error_cnt++;
    finish_test();
  end
endmodule
